/* File: core/prs_defines.vh */
// Register offsets, field positions, reset values and states of the pixel readout sequencer.
`ifndef PRS_DEFINES_VH
`define PRS_DEFINES_VH

// Register offsets on the serial register port.
`define PRS_OFF_CTRL      16'h301A
`define PRS_OFF_ORIENT    16'h3040
`define PRS_OFF_YSTART    16'h3002
`define PRS_OFF_XSTART    16'h3004
`define PRS_OFF_YEND      16'h3006
`define PRS_OFF_XEND      16'h3008
`define PRS_OFF_EXPOSURE  16'h3012
`define PRS_OFF_PEDESTAL  16'h301E
`define PRS_OFF_PIXORDER  16'h3024
`define PRS_OFF_XINC      16'h30A2
`define PRS_OFF_YINC      16'h30A6
`define PRS_OFF_MODE      16'h3100

// Field positions.
`define PRS_CTRL_STREAM   2
`define PRS_CTRL_LOCK     3
`define PRS_OR_MIRROR     14
`define PRS_OR_FLIP       15
`define PRS_MODE_GLOBAL   0
`define PRS_MODE_DIGBIN   1
`define PRS_MODE_ANABIN   2
`define PRS_MODE_ROWBIN   3

// Reset values.
`define PRS_RST_CTRL      16'h0008
`define PRS_RST_PEDESTAL  12'h0A8
`define PRS_RST_XSTART    12'h0006
`define PRS_RST_XEND      12'h0905
`define PRS_RST_YSTART    12'h0006
`define PRS_RST_YEND      12'h060D
`define PRS_RST_INC       3'h1
`define PRS_RST_EXPOSURE  16'h0010
`define PRS_LINE_LEN      16'h04B0

// Sequencer states.
`define PRS_ST_IDLE       3'h0
`define PRS_ST_ROLL       3'h1
`define PRS_ST_GRST       3'h2
`define PRS_ST_GEXP       3'h3
`define PRS_ST_GREAD      3'h4

`endif

/* File: core/prs_pedestal.v */
// Output stage that adds the pedestal to each pixel and saturates the result.
`timescale 1ns/1ps
module prs_pedestal (
  // Clock and reset.
  input  wire        clk,
  input  wire        nrst,
  // Incoming pixel.
  input  wire        in_valid,
  input  wire [11:0] in_data,
  input  wire [11:0] offset,
  // Outgoing pixel.
  output reg         out_valid,
  output reg  [11:0] out_data
);

  wire [12:0] sum = {1'b0, in_data} + {1'b0, offset};

  // Adds the offset last in the path and holds the top code instead of wrapping.
  // pedestal add
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_data  <= 12'h000;
    end else begin
      out_valid <= in_valid;
      out_data  <= sum[12] ? 12'hFFF : sum[11:0];
    end
  end

endmodule // prs_pedestal

/* File: core/prs_sequencer.v */
// Pixel array readout sequencer with windowing, orientation, skipping, binning and pedestal.
`timescale 1ns/1ps
`include "prs_defines.vh"
// Functional notes
// - A 12-bit pedestal, 168 after reset, is added to every pixel as the last step of the datapath.
// - The pedestal register only accepts writes while the lock bit, which resets to one, is zero.
// - Rolling shutter mode resets and later reads each row in turn with the same interval for every row.
// - A new exposure written while streaming takes effect only at a frame start so each frame is uniform.
// - Global mode captures one frame and drives a shutter output whose closing ends the exposure.
// - Rows walked stay inside the window registers; columns too, except that mirror starts at the end plus one
//   and digital binning reads up to 4 columns beyond the walked one; the host keeps the starts at 6 or more.
// - Mirror reverses pixel order in a row, from the last window column plus one down to the first.
// - Flip reverses row order, from the last window row down to the first.
// - The read-only color order register follows the mirror and flip settings.
// - Horizontal binning merges two or three same-color pixels, in the array or in the digital path.
// - Vertical binning merges two or three same-color rows inside the array.
// - Column skipping keeps the row period; row skipping reads fewer rows and shortens the frame.
// - Addresses advance in pairs, adding the odd increment after each pair.
// - A green-red pixel pair is read together and a green-red row precedes a blue-green row.
// - The subsampling factor in each direction is one plus the odd increment, halved.
module prs_sequencer #(
  parameter [15:0] LINE_LEN = `PRS_LINE_LEN
) (
  // Clock and reset.
  input  wire        clk,
  input  wire        nrst,
  // Register port from the serial interface.
  input  wire        reg_wr_en,
  input  wire        reg_rd_en,
  input  wire [15:0] reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  // Row control towards the pixel array.
  output reg  [11:0] arr_read_row,
  output reg         arr_row_read,
  output reg  [11:0] arr_reset_row,
  output reg         arr_row_reset,
  output reg         arr_global_reset,
  output wire        arr_row_bin_en,
  // Column control towards the pixel array.
  output reg  [11:0] arr_col,
  output reg         arr_col_rd,
  output wire        arr_col_bin_en,
  input  wire [11:0] arr_pixel,
  // Mechanical shutter control.
  output reg         shutter_open,
  // Pixel stream to the host.
  output wire        pix_valid,
  output wire [11:0] pix_data,
  output reg         frame_valid,
  output reg         frame_start
);

  localparam [2:0] ST_IDLE  = `PRS_ST_IDLE;
  localparam [2:0] ST_ROLL  = `PRS_ST_ROLL;
  localparam [2:0] ST_GRST  = `PRS_ST_GRST;
  localparam [2:0] ST_GEXP  = `PRS_ST_GEXP;
  localparam [2:0] ST_GREAD = `PRS_ST_GREAD;

  // Software registers.
  reg  [15:0] ctrl_reg;
  reg  [15:0] orient_reg;
  reg  [3:0]  mode_reg;
  reg  [11:0] xs_reg;
  reg  [11:0] xe_reg;
  reg  [11:0] ys_reg;
  reg  [11:0] ye_reg;
  reg  [2:0]  xinc_reg;
  reg  [2:0]  yinc_reg;
  reg  [15:0] exp_reg;
  reg  [11:0] ped_reg;
  reg  [1:0]  order_reg;
  // Sequencer state.
  reg  [2:0]  state_reg;
  reg  [15:0] row_tmr_reg;
  reg  [11:0] seq_reg;
  reg  [11:0] exp_lat_reg;
  reg         stream_d_reg;
  reg         col_run_reg;
  reg  [11:0] col_idx_reg;
  reg  [1:0]  sub_reg;
  // Binning pipeline.
  reg         s1_first_reg;
  reg         s1_last_reg;
  reg  [1:0]  s1_fac_reg;
  reg  [13:0] acc_reg;
  reg         bin_vld_reg;
  reg  [11:0] bin_val_reg;

  wire lock    = ctrl_reg[`PRS_CTRL_LOCK];
  wire stream  = ctrl_reg[`PRS_CTRL_STREAM];
  wire mirror  = orient_reg[`PRS_OR_MIRROR];
  wire flip    = orient_reg[`PRS_OR_FLIP];
  wire gmode   = mode_reg[`PRS_MODE_GLOBAL];

  // Walks pairs: offset is pair times (one plus increment) plus the position in the pair.
  function [12:0] walk;
    input [11:0] idx;
    input [11:0] base;
    input [11:0] span;
    input [2:0]  inc;
    input        rev;
    reg   [31:0] prod;
    reg   [15:0] off;
    begin
      prod = {21'd0, idx[11:1]} * {28'd0, {1'b0, inc} + 4'd1};
      off  = prod[15:0] + {15'd0, idx[0]};
      walk = {off <= {4'd0, span}, rev ? base - off[11:0] : base + off[11:0]};
    end
  endfunction

  // Window bounds, reversed for flip and mirror.
  // window bounds
  wire [11:0] yspan = ye_reg - ys_reg;
  wire [11:0] ybase = flip ? ye_reg : ys_reg;
  wire [11:0] xend1 = xe_reg + 12'd1;
  wire [11:0] xspan = mirror ? xend1 - xs_reg : xe_reg - xs_reg;
  wire [11:0] xbase = mirror ? xend1 : xs_reg;

  // Read row lags the reset row by the latched exposure in rolling mode.
  // equal reset-read spacing
  wire        rolling = (state_reg == ST_ROLL);
  wire [11:0] rd_idx  = rolling ? seq_reg - exp_lat_reg : seq_reg;
  wire        rd_go   = !rolling || (seq_reg >= exp_lat_reg);
  wire [12:0] rd_w    = walk(rd_idx, ybase, yspan, yinc_reg, flip);
  wire [12:0] rs_w    = walk(seq_reg, ybase, yspan, yinc_reg, flip);
  wire        rd_ok   = rd_go && rd_w[12];
  wire        rs_ok   = rs_w[12];
  wire        row_tick = (row_tmr_reg == LINE_LEN - 16'd1);

  // Horizontal factor is one plus increment, halved, when that gives 2 or 3; otherwise 1.
  // subsampling factor
  wire [3:0]  xstep = {1'b0, xinc_reg} + 4'd1;
  wire [1:0]  xfac  = (xstep[3:1] == 3'd3) ? 2'd3 : (xstep[3:1] == 3'd2) ? 2'd2 : 2'd1;
  wire        dbin  = mode_reg[`PRS_MODE_DIGBIN] && (xfac != 2'd1);
  wire [1:0]  nsub  = dbin ? xfac : 2'd1;

  // Array-side binning enables come straight from the mode bits.
  // analog column bin
  assign arr_col_bin_en = mode_reg[`PRS_MODE_ANABIN];
  assign arr_row_bin_en = mode_reg[`PRS_MODE_ROWBIN];

  // Column walk with same-color neighbours two apart for digital binning.
  // green-red pairs first
  wire [12:0] col_w   = walk(col_idx_reg, xbase, xspan, xinc_reg, mirror);
  wire [11:0] sub_off = {9'd0, sub_reg, 1'b0};
  wire [11:0] col_adr = mirror ? col_w[11:0] - sub_off : col_w[11:0] + sub_off;
  wire        sub_end = (sub_reg == nsub - 2'd1);

  // Register writes; the pedestal is guarded by the lock bit.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg   <= `PRS_RST_CTRL;
      orient_reg <= 16'h0000;
      mode_reg   <= 4'h0;
      xs_reg     <= `PRS_RST_XSTART;
      xe_reg     <= `PRS_RST_XEND;
      ys_reg     <= `PRS_RST_YSTART;
      ye_reg     <= `PRS_RST_YEND;
      xinc_reg   <= `PRS_RST_INC;
      yinc_reg   <= `PRS_RST_INC;
      exp_reg    <= `PRS_RST_EXPOSURE;
      ped_reg    <= `PRS_RST_PEDESTAL;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `PRS_OFF_CTRL:     ctrl_reg   <= reg_wdata;
        `PRS_OFF_ORIENT:   orient_reg <= reg_wdata & 16'hC000;
        `PRS_OFF_MODE:     mode_reg   <= reg_wdata[3:0];
        `PRS_OFF_XSTART:   xs_reg     <= reg_wdata[11:0];
        `PRS_OFF_XEND:     xe_reg     <= reg_wdata[11:0];
        `PRS_OFF_YSTART:   ys_reg     <= reg_wdata[11:0];
        `PRS_OFF_YEND:     ye_reg     <= reg_wdata[11:0];
        `PRS_OFF_XINC:     xinc_reg   <= reg_wdata[2:0];
        `PRS_OFF_YINC:     yinc_reg   <= reg_wdata[2:0];
        `PRS_OFF_EXPOSURE: exp_reg    <= reg_wdata;
        `PRS_OFF_PEDESTAL: begin
          if (!lock) begin
            ped_reg <= reg_wdata[11:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Color phase tracks orientation and window start parity.
  // color order update
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      order_reg <= 2'b00;
    end else begin
      order_reg <= {flip ^ ys_reg[0], mirror ^ xs_reg[0]};
    end
  end

  // Registered read data; unmapped offsets read zero.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd_en) begin
      case (reg_addr)
        `PRS_OFF_CTRL:     reg_rdata <= ctrl_reg;
        `PRS_OFF_ORIENT:   reg_rdata <= orient_reg;
        `PRS_OFF_MODE:     reg_rdata <= {12'h000, mode_reg};
        `PRS_OFF_XSTART:   reg_rdata <= {4'h0, xs_reg};
        `PRS_OFF_XEND:     reg_rdata <= {4'h0, xe_reg};
        `PRS_OFF_YSTART:   reg_rdata <= {4'h0, ys_reg};
        `PRS_OFF_YEND:     reg_rdata <= {4'h0, ye_reg};
        `PRS_OFF_XINC:     reg_rdata <= {13'h0000, xinc_reg};
        `PRS_OFF_YINC:     reg_rdata <= {13'h0000, yinc_reg};
        `PRS_OFF_EXPOSURE: reg_rdata <= exp_reg;
        `PRS_OFF_PEDESTAL: reg_rdata <= {4'h0, ped_reg};
        `PRS_OFF_PIXORDER: reg_rdata <= {14'h0000, order_reg};
        default:           reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Row timer runs freely so the row period never depends on columns walked.
  // fixed row period
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      row_tmr_reg <= 16'h0000;
    end else begin
      row_tmr_reg <= row_tick ? 16'h0000 : row_tmr_reg + 16'd1;
    end
  end

  // Frame sequencer for rolling and global modes, acting on row boundaries except the global start, taken on the stream rising edge.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg        <= ST_IDLE;
      seq_reg          <= 12'h000;
      exp_lat_reg      <= 12'h000;
      stream_d_reg     <= 1'b0;
      arr_read_row     <= 12'h000;
      arr_row_read     <= 1'b0;
      arr_reset_row    <= 12'h000;
      arr_row_reset    <= 1'b0;
      arr_global_reset <= 1'b0;
      shutter_open     <= 1'b0;
      frame_valid      <= 1'b0;
      frame_start      <= 1'b0;
    end else begin
      stream_d_reg     <= stream;
      arr_row_read     <= 1'b0;
      arr_row_reset    <= 1'b0;
      arr_global_reset <= 1'b0;
      frame_start      <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          frame_valid <= 1'b0;
          if (row_tick && stream && !gmode) begin
            exp_lat_reg <= exp_reg[11:0];
            seq_reg     <= 12'h000;
            frame_start <= 1'b1;
            frame_valid <= 1'b1;
            state_reg   <= ST_ROLL;
          end else if (gmode && stream && !stream_d_reg) begin
            exp_lat_reg      <= exp_reg[11:0];
            arr_global_reset <= 1'b1;
            state_reg        <= ST_GRST;
          end
        end
        ST_ROLL: begin
          if (row_tick) begin
            if (rs_ok) begin
              arr_reset_row <= rs_w[11:0];
              arr_row_reset <= 1'b1;
            end
            if (rd_ok) begin
              arr_read_row <= rd_w[11:0];
              arr_row_read <= 1'b1;
            end
            if (rd_go && !rd_ok) begin
              exp_lat_reg <= exp_reg[11:0];
              seq_reg     <= 12'h000;
              frame_start <= stream;
              frame_valid <= stream;
              state_reg   <= stream ? ST_ROLL : ST_IDLE;
            end else begin
              seq_reg <= seq_reg + 12'd1;
            end
          end
        end
        ST_GRST: begin
          if (row_tick) begin
            shutter_open <= 1'b1;
            seq_reg      <= 12'h000;
            state_reg    <= ST_GEXP;
          end
        end
        ST_GEXP: begin
          if (row_tick) begin
            if (seq_reg == exp_lat_reg) begin
              shutter_open <= 1'b0;
              seq_reg      <= 12'h000;
              frame_start  <= 1'b1;
              frame_valid  <= 1'b1;
              state_reg    <= ST_GREAD;
            end else begin
              seq_reg <= seq_reg + 12'd1;
            end
          end
        end
        ST_GREAD: begin
          if (row_tick) begin
            if (rd_ok) begin
              arr_read_row <= rd_w[11:0];
              arr_row_read <= 1'b1;
              seq_reg      <= seq_reg + 12'd1;
            end else begin
              frame_valid <= 1'b0;
              state_reg   <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Column walk starts after each row read and stops when leaving the window.
  // column pair stepping
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      col_run_reg  <= 1'b0;
      col_idx_reg  <= 12'h000;
      sub_reg      <= 2'd0;
      arr_col      <= 12'h000;
      arr_col_rd   <= 1'b0;
      s1_first_reg <= 1'b0;
      s1_last_reg  <= 1'b0;
      s1_fac_reg   <= 2'd1;
    end else begin
      arr_col_rd <= 1'b0;
      if (arr_row_read) begin
        col_run_reg <= 1'b1;
        col_idx_reg <= 12'h000;
        sub_reg     <= 2'd0;
      end else if (col_run_reg) begin
        if (!col_w[12]) begin
          col_run_reg <= 1'b0;
        end else begin
          arr_col      <= col_adr;
          arr_col_rd   <= 1'b1;
          s1_first_reg <= (sub_reg == 2'd0);
          s1_last_reg  <= sub_end;
          s1_fac_reg   <= nsub;
          if (sub_end) begin
            sub_reg     <= 2'd0;
            col_idx_reg <= col_idx_reg + 12'd1;
          end else begin
            sub_reg <= sub_reg + 2'd1;
          end
        end
      end
    end
  end

  // Digital binning: sum same-color samples and scale by the factor.
  // digital column bin
  wire [13:0] acc_sum = (s1_first_reg ? 14'd0 : acc_reg) + {2'b00, arr_pixel};
  wire [23:0] third   = {10'd0, acc_sum} * 24'd683;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg     <= 14'd0;
      bin_vld_reg <= 1'b0;
      bin_val_reg <= 12'h000;
    end else begin
      bin_vld_reg <= arr_col_rd && s1_last_reg;
      if (arr_col_rd) begin
        acc_reg <= acc_sum;
        if (s1_last_reg) begin
          case (s1_fac_reg)
            2'd2:    bin_val_reg <= acc_sum[12:1];
            2'd3:    bin_val_reg <= third[22:11];
            default: bin_val_reg <= acc_sum[11:0];
          endcase
        end
      end
    end
  end

  // Final stage adds the pedestal.
  // pedestal at output
  prs_pedestal u_pedestal (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (bin_vld_reg),
    .in_data   (bin_val_reg),
    .offset    (ped_reg),
    .out_valid (pix_valid),
    .out_data  (pix_data)
  );

endmodule // prs_sequencer

/* File: testbench/prs_checker.sv */
// Concurrent checks on the ports of the pixel readout sequencer.
`timescale 1ns/1ps
`include "prs_defines.vh"
module prs_checker #(
  parameter [15:0] LINE_LEN = `PRS_LINE_LEN
) (
  // Clock and reset.
  input wire        clk,
  input wire        nrst,
  // Register port.
  input wire        reg_wr_en,
  input wire        reg_rd_en,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  // Array side.
  input wire [11:0] arr_read_row,
  input wire        arr_row_read,
  input wire        arr_global_reset,
  input wire        arr_row_bin_en,
  input wire        arr_col_rd,
  input wire        arr_col_bin_en,
  input wire [11:0] arr_pixel,
  input wire        shutter_open,
  // Pixel stream.
  input wire        pix_valid,
  input wire [11:0] pix_data,
  input wire        frame_valid,
  input wire        frame_start
);
  reg         lock_s;
  reg         dbin_s;
  reg         seen;
  reg  [11:0] ped_s;
  reg  [11:0] ys_s;
  reg  [11:0] ye_s;
  reg  [11:0] e1;
  reg  [11:0] e2;
  reg  [15:0] gap;
  wire [12:0] sum = arr_pixel + ped_s;

  // Shadows of the registers, expected pixel pipeline and the gap between row reads.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_s <= 1'b1;
      dbin_s <= 1'b0;
      seen   <= 1'b0;
      ped_s  <= `PRS_RST_PEDESTAL;
      ys_s   <= `PRS_RST_YSTART;
      ye_s   <= `PRS_RST_YEND;
      e1     <= 12'h000;
      e2     <= 12'h000;
      gap    <= 16'h0000;
    end else begin
      if (reg_wr_en && reg_addr == `PRS_OFF_CTRL)
        lock_s <= reg_wdata[`PRS_CTRL_LOCK];
      if (reg_wr_en && reg_addr == `PRS_OFF_MODE)
        dbin_s <= reg_wdata[`PRS_MODE_DIGBIN];
      if (reg_wr_en && reg_addr == `PRS_OFF_PEDESTAL && !lock_s)
        ped_s <= reg_wdata[11:0];
      if (reg_wr_en && reg_addr == `PRS_OFF_YSTART)
        ys_s <= reg_wdata[11:0];
      if (reg_wr_en && reg_addr == `PRS_OFF_YEND)
        ye_s <= reg_wdata[11:0];
      e1   <= sum[12] ? 12'hFFF : sum[11:0];
      e2   <= e1;
      gap  <= arr_row_read ? 16'h0001 : gap + 16'h0001;
      seen <= frame_valid & (seen | arr_row_read);
    end
  end

  // A plain sample and the pixel it must yield two cycles later.
  sequence s_sample;
    arr_col_rd && !dbin_s;
  endsequence
  sequence s_out;
    ##2 pix_valid && pix_data == e2;
  endsequence

  property p_pix_path;
    @(posedge clk) disable iff (!nrst) s_sample |-> s_out;
  endproperty
  a_pix_path: assert property (p_pix_path) else $error("pixel plus pedestal wrong");

  property p_ped_read;
    @(posedge clk) disable iff (!nrst)
      reg_rd_en && !reg_wr_en && reg_addr == `PRS_OFF_PEDESTAL |=> reg_rdata[11:0] == ped_s;
  endproperty
  a_ped_read: assert property (p_ped_read) else $error("pedestal lock not kept");

  property p_row_period;
    @(posedge clk) disable iff (!nrst) arr_row_read && seen |-> gap == LINE_LEN;
  endproperty
  a_row_period: assert property (p_row_period) else $error("row period not uniform");

  property p_row_win;
    @(posedge clk) disable iff (!nrst) arr_row_read |-> arr_read_row >= ys_s && arr_read_row <= ye_s;
  endproperty
  a_row_win: assert property (p_row_win) else $error("row read outside window");

  property p_shut_end;
    @(posedge clk) disable iff (!nrst) $fell(shutter_open) |-> ##[0:1] frame_start;
  endproperty
  a_shut_end: assert property (p_shut_end) else $error("no frame after shutter");

  property p_grst;
    @(posedge clk) disable iff (!nrst) arr_global_reset |=> !shutter_open && !frame_start;
  endproperty
  a_grst: assert property (p_grst) else $error("global reset overlaps exposure end");

  property p_bins;
    @(posedge clk) disable iff (!nrst)
      reg_wr_en && reg_addr == `PRS_OFF_MODE |=> {arr_row_bin_en, arr_col_bin_en} == $past(reg_wdata[3:2]);
  endproperty
  a_bins: assert property (p_bins) else $error("binning enables wrong");

  property p_fs_pulse;
    @(posedge clk) disable iff (!nrst) frame_start |=> !frame_start && frame_valid;
  endproperty
  a_fs_pulse: assert property (p_fs_pulse) else $error("frame start not a pulse");
endmodule // prs_checker

bind prs_sequencer prs_checker #(.LINE_LEN(LINE_LEN)) u_chk (
  .clk(clk), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .arr_read_row(arr_read_row), .arr_row_read(arr_row_read),
  .arr_global_reset(arr_global_reset), .arr_row_bin_en(arr_row_bin_en), .arr_col_rd(arr_col_rd),
  .arr_col_bin_en(arr_col_bin_en), .arr_pixel(arr_pixel), .shutter_open(shutter_open),
  .pix_valid(pix_valid), .pix_data(pix_data), .frame_valid(frame_valid), .frame_start(frame_start));

/* File: testbench/prs_pixel_array.sv */
// Behavioural pixel array answering column reads with a value built from row and column.
`timescale 1ns/1ps
module prs_pixel_array (
  // Clock.
  input  wire        clk,
  // Address and strobe from the sequencer.
  input  wire [11:0] read_row,
  input  wire [11:0] col,
  input  wire        col_rd,
  // Pixel back to the sequencer.
  output wire [11:0] pixel
);
  reg [11:0] junk = 12'h5A5;

  // Outside a column read the line changes every cycle so stale data is never mistaken for valid.
  always @(posedge clk) begin
    junk <= ~pixel;
  end

  assign pixel = col_rd ? {read_row[5:0], col[5:0]} : junk;
endmodule // prs_pixel_array

/* File: testbench/tb.sv */
// Self-checking testbench for the pixel readout sequencer.
`timescale 1ns/1ps
`include "prs_defines.vh"
module tb;
  reg          clk;
  reg          nrst;
  reg          reg_wr_en;
  reg          reg_rd_en;
  reg  [15:0]  reg_addr;
  reg  [15:0]  reg_wdata;
  reg          rd_d = 1'b0;
  wire [15:0]  reg_rdata;
  wire [11:0]  arr_read_row;
  wire [11:0]  arr_col;
  wire         arr_col_rd;
  wire [11:0]  arr_pixel;
  wire         shutter_open;
  wire         pix_valid;
  wire [11:0]  pix_data;
  wire         frame_valid;
  wire         frame_start;
  integer      fails;
  integer      compares;
  integer      k;
  integer      seed;
  logic [15:0] rq[$];
  logic [15:0] pq[$];

  prs_sequencer #(.LINE_LEN(16'h0040)) DUT (
    .clk(clk), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .arr_read_row(arr_read_row), .arr_row_read(),
    .arr_reset_row(), .arr_row_reset(), .arr_global_reset(), .arr_row_bin_en(), .arr_col(arr_col),
    .arr_col_rd(arr_col_rd), .arr_col_bin_en(), .arr_pixel(arr_pixel), .shutter_open(shutter_open),
    .pix_valid(pix_valid), .pix_data(pix_data), .frame_valid(frame_valid), .frame_start(frame_start));

  prs_pixel_array u_array (
    .clk(clk), .read_row(arr_read_row), .col(arr_col), .col_rd(arr_col_rd), .pixel(arr_pixel));

  // Clock of 10 ns.
  always #5 clk = ~clk;

  task automatic chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task tally_and_finish;
    begin
      if (fails == 0 && compares > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask

  // One register access; a read notes its expected answer first.
  task acc(input w, input [15:0] a, input [15:0] d);
    begin
      if (!w)
        rq.push_back(d);
      @(posedge clk);
      #1;
      reg_wr_en = w;
      reg_rd_en = !w;
      reg_addr  = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
    end
  endtask

  // One frame: note every pixel in readout order, start streaming, stop and drain.
  task frame(input g, input m, input f, input [2:0] xi, input [2:0] yi);
    integer    r;
    integer    c;
    integer    ro;
    integer    co;
    integer    n;
    reg [11:0] ped;
    reg [12:0] s;
    reg        sh;
    begin
      ped = 12'($urandom);
      acc(1, `PRS_OFF_PEDESTAL, {4'h0, ped});
      acc(1, `PRS_OFF_ORIENT, {f, m, 14'h0000});
      acc(1, `PRS_OFF_XINC, {13'h0000, xi});
      acc(1, `PRS_OFF_YINC, {13'h0000, yi});
      acc(1, `PRS_OFF_EXPOSURE, 16'($urandom_range(3, 1)));
      acc(1, `PRS_OFF_MODE, {14'h0000, !g, g});
      for (r = 0; r < 16; r = r + 1) begin
        ro = (r / 2) * (yi + 1) + r % 2;
        for (c = 0; c < 16; c = c + 1) begin
          co = (c / 2) * (xi + 1) + c % 2;
          if (ro <= 7 && co <= 7 + m) begin
            // Rolling frames use digital binning: the mean of same-color neighbours two apart.
            s = {1'b0, ped} + 13'((f ? 13 - ro : 6 + ro) * 64 + (m ? 14 - co : 6 + co)
                + (g ? 0 : (m ? -1 : 1) * ((xi - 1) / 2)));
            pq.push_back({4'h0, (s[12] ? 12'hFFF : s[11:0])});
          end
        end
      end
      sh = 1'b0;
      n  = 0;
      acc(1, `PRS_OFF_CTRL, 16'h0004);
      while (frame_start !== 1'b1 && n < 1000) begin
        @(posedge clk);
        #1;
        sh = sh | shutter_open;
        n  = n + 1;
      end
      chk({15'h0000, frame_start}, 16'h0001);
      chk({15'h0000, sh}, {15'h0000, g});
      // New exposure mid-frame, then stop at the frame end.
      acc(1, `PRS_OFF_EXPOSURE, 16'h0002);
      acc(1, `PRS_OFF_CTRL, 16'h0000);
      n = 0;
      while (frame_valid === 1'b1 && n < 3000) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      repeat (4) @(posedge clk);
      #1;
      chk(16'(pq.size()), 16'h0000);
    end
  endtask

  // Compare register answers and output pixels with the oldest notes.
  always @(posedge clk) begin
    rd_d <= reg_rd_en;
    if (rd_d === 1'b1)
      chk(reg_rdata, rq.size() ? rq.pop_front() : 16'hFFFF);
    if (pix_valid === 1'b1)
      chk({4'h0, pix_data}, pq.size() ? pq.pop_front() : 16'hFFFF);
  end

  // Watchdog against a hang.
  initial begin
    #500000;
    fails = fails + 1;
    tally_and_finish;
  end

  // Main sequence.
  initial begin
    clk       = 1'b0;
    nrst      = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
    fails     = 0;
    compares  = 0;
    seed      = $urandom(32'h0000_512f);
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    acc(0, `PRS_OFF_CTRL, 16'h0008);
    acc(0, `PRS_OFF_PEDESTAL, 16'h00A8);
    acc(0, 16'h3000, 16'h0000);
    acc(1, `PRS_OFF_PEDESTAL, 16'h0123);
    acc(0, `PRS_OFF_PEDESTAL, 16'h00A8);
    acc(1, `PRS_OFF_CTRL, 16'h0000);
    acc(1, `PRS_OFF_PEDESTAL, 16'h0FFF);
    acc(0, `PRS_OFF_PEDESTAL, 16'h0FFF);
    acc(1, `PRS_OFF_ORIENT, 16'hFFFF);
    acc(0, `PRS_OFF_ORIENT, 16'hC000);
    acc(1, `PRS_OFF_MODE, 16'h000C);
    acc(0, `PRS_OFF_MODE, 16'h000C);
    for (k = 0; k < 8; k = k + 1) begin
      acc(1, `PRS_OFF_XSTART, 16'(6 + k / 4));
      acc(1, `PRS_OFF_YSTART, 16'(6 + k / 4));
      acc(1, `PRS_OFF_ORIENT, {k[1], k[0], 14'h0000});
      acc(1, `PRS_OFF_PIXORDER, 16'h0003);
      acc(0, `PRS_OFF_PIXORDER, {14'h0000, k[1] ^ k[2], k[0] ^ k[2]});
    end
    acc(1, `PRS_OFF_XSTART, 16'h0006);
    acc(1, `PRS_OFF_YSTART, 16'h0006);
    acc(1, `PRS_OFF_XEND, 16'h000D);
    acc(1, `PRS_OFF_YEND, 16'h000D);
    for (k = 0; k < 8; k = k + 1)
      frame(k[2] & k[1], k[0], k[1], 3'(1 + 2 * (k % 3)), 3'(1 + 2 * ((k / 3) % 3)));
    tally_and_finish;
  end
endmodule // tb
